// ===== src/scp_pkg.sv
// Package for the serial control word port: field positions, mode codes and reset values.
// Assumes a single clk domain at 100 MHz; all users reference names with scp_pkg:: prefix.
package scp_pkg;
   localparam int WORD_BITS = 16;
   // Field positions in the control word.
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 3;
   localparam int CFG_LSB = 3;
   localparam int CFG_W = 2;
   localparam int PAY_LSB = 5;
   localparam int PAY_W = 9;
   localparam int MEAS_BIT = 14;
   localparam int WDOG_BIT = 15;
   // Mode selection codes.
   localparam logic [2:0] MODE_ACT_LIN_SLEEP = 3'h2;
   localparam logic [2:0] MODE_ACT_LIN_ON = 3'h3;
   localparam logic [2:0] MODE_SLEEP = 3'h4;
   localparam logic [2:0] MODE_RX_ONLY = 3'h6;
   localparam logic [2:0] MODE_STOP = 3'h7;
   // Configuration selection codes.
   localparam logic [1:0] CFG_GENERAL = 2'h0;
   localparam logic [1:0] CFG_SWITCH = 2'h1;
   localparam logic [1:0] CFG_CYCLIC = 2'h2;
   localparam logic [1:0] CFG_WDOG = 2'h3;
   // Values after reset.
   localparam logic [2:0] MODE_RESET = 3'h2;
   localparam logic [8:0] PAY_RESET = 9'h000;
   localparam logic [15:0] DIAG_RESET = 16'h0000;
   // Bit counter width for modulo-16 supervision.
   localparam int CNT_W = 4;
   typedef enum logic [2:0]
   {
      SCP_IDLE = 3'b001,
      SCP_XFER = 3'b010,
      SCP_DONE = 3'b100
   } scp_state_e;
endpackage

// ===== src/scp_port.sv
// Serial slave port that receives the 16-bit control word and returns a diagnosis word.
// Assumes the master drives the serial clock and chip select; pins are sampled on clk.
`timescale 1ns/100ps
// Functional notes
// RQ1 - One 16-bit word in LSB first, diagnosis word out in the same transfer.
// RQ2 - Master supplies the serial clock; the port only samples it.
// RQ3 - Master drives chip select low for the whole word.
// RQ4 - Chip select rising adopts shifted-in bits as control word if count passes.
// RQ5 - Chip select rising releases the serial data output to high impedance.
// RQ6 - Serial input sampled on each falling serial clock edge.
// RQ7 - Output register advances after each rising serial clock edge.
// RQ8 - Clocks counted modulo sixteen; word discarded on mismatch.
// RQ9 - After a rejected word, output driven high before next first rising edge.
// RQ10 - During error report, output equals error OR current serial input.
// RQ11 - Bits 0 to 2 form the mode selection field.
// RQ12 - Bits 3 and 4 form the configuration selection field.
// RQ13 - Bits 5 to 13 are payload interpreted by configuration selection.
// RQ14 - Bit 14 enables measurement only in active mode; forced off otherwise.
// RQ15 - Bit 15 gates watchdog only in stop and sleep; active keeps it on.
// RQ16 - Bit 15 set before stop keeps watchdog on despite low load current.
// RQ17 - Mode codes 010,011,100,110,111 decoded; 000,001,101 reserved.
// RQ18 - After wake, master commands active first, then switches on.
// RQ19 - Configuration select: general, switch, cyclic wake, watchdog.
// RQ20 - Reserved mode codes keep the current mode; other fields still apply.
module scp_port
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic chip_select_low,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic [15:0] diag_word,
   input wire logic low_load_current,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   output logic [2:0] mode_q,
   output logic [8:0] general_cfg_q,
   output logic [8:0] switch_cfg_q,
   output logic [8:0] cyclic_cfg_q,
   output logic [8:0] wdog_cfg_q,
   output logic meas_on_q,
   output logic wdog_on_q,
   output logic word_valid_q,
   output logic count_error_q
);
   //------------------------------------------------------------
   // Reset release and pin synchronisation
   //------------------------------------------------------------
   logic rst1_q;
   logic rst_n;
   logic cs_low;
   logic sclk;
   logic sdi;
   logic cs_low_prev_q;
   logic sclk_prev_q;

   // Reset is released through two flip-flops.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst1_q <= 1'b1;
         rst_n <= rst1_q;
      end
   end

   // RQ2 serial clock sampled
   scp_sync #(.INIT(1'b1)) u_sync_cs (.clk(clk), .rst_n(rst_n), .pin(chip_select_low), .level_q(cs_low));
   scp_sync #(.INIT(1'b0)) u_sync_clk (.clk(clk), .rst_n(rst_n), .pin(serial_clk), .level_q(sclk));
   scp_sync #(.INIT(1'b0)) u_sync_data (.clk(clk), .rst_n(rst_n), .pin(serial_data_in), .level_q(sdi));
   // Previous levels for edge detection.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_low_prev_q <= 1'b1;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         cs_low_prev_q <= cs_low;
         sclk_prev_q <= sclk;
      end
   end

   //------------------------------------------------------------
   // Edge decode and transfer state
   //------------------------------------------------------------
   wire cs_fall = cs_low_prev_q & ~cs_low;
   wire cs_rise = ~cs_low_prev_q & cs_low;
   wire active = ~cs_low;
   wire clk_fall = active & sclk_prev_q & ~sclk;
   wire clk_rise = active & ~sclk_prev_q & sclk;

   scp_pkg::scp_state_e state_q;
   scp_pkg::scp_state_e state_d;
   logic [scp_pkg::CNT_W-1:0] cnt_q;
   logic any_clk_q;
   logic err_pend_q;
   logic err_show_q;
   logic [15:0] rx_word;
   logic [15:0] tx_word;

   // Next state: idle until select, transfer until release, one cycle to apply.
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         scp_pkg::SCP_IDLE: if (cs_fall) state_d = scp_pkg::SCP_XFER;
         scp_pkg::SCP_XFER: if (cs_rise) state_d = scp_pkg::SCP_DONE;
         scp_pkg::SCP_DONE: state_d = scp_pkg::SCP_IDLE;
         default: state_d = scp_pkg::SCP_IDLE;
      endcase
   end

   // RQ8 modulo sixteen count
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= scp_pkg::SCP_IDLE;
         cnt_q <= '0;
         any_clk_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (cs_fall)
         begin
            cnt_q <= '0;
            any_clk_q <= 1'b0;
         end
         else if (clk_fall)
         begin
            cnt_q <= cnt_q + 1'b1;
            any_clk_q <= 1'b1;
         end
      end
   end

   // Count passes when it is a nonzero whole multiple of sixteen; only a release that closes an open transfer is judged.
   wire count_ok = (cnt_q == '0) & any_clk_q;
   wire apply = cs_rise & count_ok & (state_q == scp_pkg::SCP_XFER);
   wire reject = cs_rise & ~count_ok & (state_q == scp_pkg::SCP_XFER);

   //------------------------------------------------------------
   // Shift registers
   //------------------------------------------------------------
   // RQ6 sample on falling edge
   scp_shift #(.W(scp_pkg::WORD_BITS)) u_rx
   (
      .clk(clk),
      .rst_n(rst_n),
      .load(1'b0),
      .load_val(16'h0000),
      .shift(clk_fall),
      .bit_in(sdi),
      .data_q(rx_word)
   );

   // RQ1 RQ7 diagnosis word shifted out
   scp_shift #(.W(scp_pkg::WORD_BITS)) u_tx
   (
      .clk(clk),
      .rst_n(rst_n),
      .load(cs_fall),
      .load_val(diag_word),
      .shift(clk_rise),
      .bit_in(1'b0),
      .data_q(tx_word)
   );

   //------------------------------------------------------------
   // Error flag and serial output
   //------------------------------------------------------------
   // RQ9 error pending set on reject
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         err_pend_q <= 1'b0;
         err_show_q <= 1'b0;
      end
      else
      begin
         if (reject)
         begin
            err_pend_q <= 1'b1;
         end
         else if (cs_fall)
         begin
            err_pend_q <= 1'b0;
         end
         if (cs_fall)
         begin
            err_show_q <= err_pend_q;
         end
         else if (clk_rise | cs_rise)
         begin
            err_show_q <= 1'b0;
         end
      end
   end
   // RQ10 error ORed with input
   wire out_bit = err_show_q ? (1'b1 | sdi) : tx_word[0];
   // RQ5 release output on deselect
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serial_data_out <= 1'b0;
         serial_data_out_oe <= 1'b0;
      end
      else
      begin
         serial_data_out <= out_bit;
         serial_data_out_oe <= active & ~cs_rise;
      end
   end

   //------------------------------------------------------------
   // Control word decode
   //------------------------------------------------------------
   // RQ11 mode field
   wire [2:0] new_mode = rx_word[scp_pkg::MODE_LSB +: scp_pkg::MODE_W];
   // RQ12 configuration field
   wire [1:0] new_cfg = rx_word[scp_pkg::CFG_LSB +: scp_pkg::CFG_W];
   // RQ13 payload field
   wire [8:0] new_pay = rx_word[scp_pkg::PAY_LSB +: scp_pkg::PAY_W];
   // RQ17 valid mode codes
   wire mode_known = (new_mode == scp_pkg::MODE_ACT_LIN_SLEEP) | (new_mode == scp_pkg::MODE_ACT_LIN_ON)
                   | (new_mode == scp_pkg::MODE_SLEEP) | (new_mode == scp_pkg::MODE_RX_ONLY)
                   | (new_mode == scp_pkg::MODE_STOP);
   wire is_active = (mode_q == scp_pkg::MODE_ACT_LIN_SLEEP) | (mode_q == scp_pkg::MODE_ACT_LIN_ON);
   wire is_low_pwr = (mode_q == scp_pkg::MODE_SLEEP) | (mode_q == scp_pkg::MODE_STOP);
   logic meas_bit_q;
   logic wdog_bit_q;
   logic wdog_latched_q;

   // RQ4 adopt word on release
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= scp_pkg::MODE_RESET;
         general_cfg_q <= scp_pkg::PAY_RESET;
         switch_cfg_q <= scp_pkg::PAY_RESET;
         cyclic_cfg_q <= scp_pkg::PAY_RESET;
         wdog_cfg_q <= scp_pkg::PAY_RESET;
         meas_bit_q <= 1'b0;
         wdog_bit_q <= 1'b0;
         wdog_latched_q <= 1'b0;
         word_valid_q <= 1'b0;
         count_error_q <= 1'b0;
      end
      else
      begin
         word_valid_q <= apply;
         count_error_q <= reject;
         if (apply)
         begin
            // RQ20 reserved mode kept
            if (mode_known)
            begin
               mode_q <= new_mode;
            end
            // RQ19 configuration set select
            case (new_cfg)
               scp_pkg::CFG_GENERAL: general_cfg_q <= new_pay;
               scp_pkg::CFG_SWITCH: switch_cfg_q <= new_pay;
               scp_pkg::CFG_CYCLIC: cyclic_cfg_q <= new_pay;
               scp_pkg::CFG_WDOG: wdog_cfg_q <= new_pay;
               default: general_cfg_q <= general_cfg_q;
            endcase
            meas_bit_q <= rx_word[scp_pkg::MEAS_BIT];
            wdog_bit_q <= rx_word[scp_pkg::WDOG_BIT];
            // RQ16 watchdog latched before stop
            if (mode_known & (new_mode == scp_pkg::MODE_STOP) & (mode_q != scp_pkg::MODE_STOP))
            begin
               wdog_latched_q <= wdog_bit_q | rx_word[scp_pkg::WDOG_BIT];
            end
         end
      end
   end

   // RQ14 measurement only in active
   wire meas_d = meas_bit_q & is_active;
   // RQ15 watchdog always on in active
   wire wdog_d = is_active | (is_low_pwr & wdog_bit_q & (~low_load_current | wdog_latched_q))
               | (~is_active & ~is_low_pwr);
   // Registered gated controls.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meas_on_q <= 1'b0;
         wdog_on_q <= 1'b1;
      end
      else
      begin
         meas_on_q <= meas_d;
         wdog_on_q <= wdog_d;
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   a_release_tristate: // RQ5
      assert property (@(posedge clk) disable iff (!rst_n) cs_rise |=> !serial_data_out_oe)
      else $error("output still driven after deselect");
   a_bad_count_drop: // RQ8
      assert property (@(posedge clk) disable iff (!rst_n) reject |=> !word_valid_q && $stable(mode_q))
      else $error("bad length word applied");
   a_error_shown: // RQ9
      assert property (@(posedge clk) disable iff (!rst_n) (cs_fall && err_pend_q) |=> ##1 serial_data_out)
      else $error("count error not reported");
   a_meas_forced_off: // RQ14
      assert property (@(posedge clk) disable iff (!rst_n) !is_active |=> !meas_on_q)
      else $error("measurement on outside active mode");
   a_wdog_active_on: // RQ15
      assert property (@(posedge clk) disable iff (!rst_n) is_active |=> wdog_on_q)
      else $error("watchdog off in active mode");
   a_reserved_mode_kept: // RQ20
      assert property (@(posedge clk) disable iff (!rst_n) (apply && !mode_known) |=> $stable(mode_q))
      else $error("reserved code changed mode");
   a_mode_adopted: // RQ4
      assert property (@(posedge clk) disable iff (!rst_n) (apply && mode_known) |=> mode_q == $past(new_mode))
      else $error("valid mode not adopted");
   a_shift_lsb_first: // RQ6
      assert property (@(posedge clk) disable iff (!rst_n) clk_fall |=> rx_word[15] == $past(sdi))
      else $error("input bit not captured");
endmodule

// ===== src/scp_shift.sv
// Sixteen-bit shift register, LSB first, with parallel load.
// Assumes shift and load are single-cycle strobes on clk.
`timescale 1ns/100ps
module scp_shift
#(
   parameter int W = 16
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic shift,
   input wire logic bit_in,
   output logic [W-1:0] data_q
);
   // Load has priority; a shift moves bits toward the LSB and inserts at the MSB.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_q <= '0;
      end
      else if (load)
      begin
         data_q <= load_val;
      end
      else if (shift)
      begin
         data_q <= {bit_in, data_q[W-1:1]};
      end
   end
endmodule

// ===== src/scp_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes clk is the block clock; rst_n is the already synchronised reset.
`timescale 1ns/100ps
module scp_sync
#(
   parameter logic INIT = 1'b0
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // Stage chain; the output changes only when stages two and three agree.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         level_q <= INIT;
      end
      else
      begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            level_q <= s3_q;
         end
      end
   end
endmodule

// ===== tb/scp_master.sv
// Behavioural master of the serial control word port, one frame per call.
// Assumes the bench clock clk; the serial clock stands low between frames.
`timescale 1ns/100ps
module scp_master
(
   input wire logic clk,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire logic word_valid_q,
   input wire logic count_error_q,
   output logic chip_select_low,
   output logic serial_clk,
   output logic serial_data_in
);
   // Idle levels: not selected, clock parked low.
   initial
   begin
      chip_select_low = 1'b1;
      serial_clk = 1'b0;
      serial_data_in = 1'b0;
   end

   // Waits n cycles and lands just after a rising edge of clk.
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Sends nclk clocks of w, LSB first; extra leading clocks carry inverted bits.
   task automatic xfer(input logic [15:0] w, input int nclk, output logic [15:0] rx, output logic ok,
                       output logic bad, output logic drv);
      logic b;
      b = 1'b0;
      drv = 1'b0;
      rx = 16'h0000;
      ok = 1'b0;
      bad = 1'b0;
      wait_clk(1);
      chip_select_low = 1'b0;
      wait_clk(10);
      // The port must be driving its output by now, whatever the clock count.
      drv = serial_data_out_oe;
      for (int i = 0; i < nclk; i++)
      begin
         b = (i < nclk - 16) ? ~w[i % 16] : w[i % 16];
         serial_data_in = b;
         if (i < 16)
            rx[i] = serial_data_out;
         serial_clk = 1'b1;
         wait_clk(4);
         serial_clk = 1'b0;
         wait_clk(4);
      end
      wait_clk(4);
      chip_select_low = 1'b1;
      // Released data line shows the inverse of its last level.
      serial_data_in = ~b;
      for (int k = 0; k < 20; k++)
      begin
         wait_clk(1);
         ok = ok | (word_valid_q === 1'b1);
         bad = bad | (count_error_q === 1'b1);
      end
   endtask
endmodule

// ===== tb/tb_sbc_spi_control_word_port.sv
// Self-checking bench for the serial control word port.
// Assumes scp_pkg, scp_port and its submodules are compiled first.
`timescale 1ns/100ps
module tb_sbc_spi_control_word_port;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic chip_select_low, serial_clk, serial_data_in;
   logic [15:0] diag_word = 16'h0000;
   logic low_load_current = 1'b0;
   logic serial_data_out, serial_data_out_oe, meas_on_q, wdog_on_q, word_valid_q, count_error_q;
   logic [2:0] mode_q;
   logic [8:0] general_cfg_q, switch_cfg_q, cyclic_cfg_q, wdog_cfg_q;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   logic err_pend = 1'b0;
   logic [8:0] exp_cfg [4] = '{9'h000, 9'h000, 9'h000, 9'h000};

   scp_port uut (.clk(clk), .resetn(resetn), .chip_select_low(chip_select_low), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .diag_word(diag_word), .low_load_current(low_load_current),
      .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe), .mode_q(mode_q),
      .general_cfg_q(general_cfg_q), .switch_cfg_q(switch_cfg_q), .cyclic_cfg_q(cyclic_cfg_q),
      .wdog_cfg_q(wdog_cfg_q), .meas_on_q(meas_on_q), .wdog_on_q(wdog_on_q), .word_valid_q(word_valid_q),
      .count_error_q(count_error_q));

   scp_master m (.clk(clk), .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
      .word_valid_q(word_valid_q),
      .count_error_q(count_error_q), .chip_select_low(chip_select_low), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in));

   // Clock of 10 ns period.
   always #5 clk = ~clk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Compares one value with its expectation.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [15:0] mk(input logic [2:0] md, input logic [1:0] cf, input logic [8:0] pl,
                                      input logic me, input logic wd);
      return {wd, me, pl, cf, md};
   endfunction

   // One frame; checks the returned diagnosis word, the verdict and the release of the output.
   task automatic send(input logic [15:0] w, input int nclk);
      logic [15:0] rx;
      logic ok, bad, good, drv;
      good = (nclk == 16) || (nclk == 32);
      m.xfer(w, nclk, rx, ok, bad, drv);
      chk(drv, 1'b1);
      if (nclk >= 16)
         chk(rx, err_pend ? {diag_word[15:1], 1'b1} : diag_word);
      chk(ok, good);
      chk(bad, !good);
      chk(serial_data_out_oe, 1'b0);
      err_pend = !good;
   endtask

   // Compares the four payload sets with their expectations.
   task automatic chk_cfg();
      chk(general_cfg_q, exp_cfg[0]);
      chk(switch_cfg_q, exp_cfg[1]);
      chk(cyclic_cfg_q, exp_cfg[2]);
      chk(wdog_cfg_q, exp_cfg[3]);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(mode_q, scp_pkg::MODE_RESET);
      chk(wdog_on_q, 1'b1);
      chk(meas_on_q, 1'b0);
      chk(serial_data_out_oe, 1'b0);
      chk_cfg();
   endtask

   // Each configuration set in turn; others must hold.
   task automatic t_fields();
      logic [8:0] pay;
      for (int c = 0; c < 4; c++)
      begin
         pay = 9'(167 + 77 * c);
         diag_word = 16'(16'h3C5A + c * 16'h1357);
         send(mk(scp_pkg::MODE_ACT_LIN_ON, 2'(c), pay, 1'b1, 1'b0), 16);
         exp_cfg[c] = pay;
         chk_cfg();
         chk(mode_q, scp_pkg::MODE_ACT_LIN_ON);
         chk(meas_on_q, 1'b1);
         chk(wdog_on_q, 1'b1);
      end
   endtask

   // Every mode code; reserved ones keep the mode but still apply the payload.
   task automatic t_modes();
      logic [2:0] em;
      logic [8:0] pay;
      em = scp_pkg::MODE_ACT_LIN_ON;
      for (int k = 0; k < 8; k++)
      begin
         pay = 9'(37 * k + 1);
         send(mk(3'(k), scp_pkg::CFG_GENERAL, pay, 1'b1, 1'b1), 16);
         if (k != 0 && k != 1 && k != 5)
            em = 3'(k);
         exp_cfg[0] = pay;
         chk(mode_q, em);
         chk(meas_on_q, em == scp_pkg::MODE_ACT_LIN_SLEEP || em == scp_pkg::MODE_ACT_LIN_ON);
         chk_cfg();
      end
   endtask

   // Watchdog under low load current, in active and in stop.
   task automatic t_wdog();
      low_load_current = 1'b1;
      send(mk(scp_pkg::MODE_ACT_LIN_SLEEP, scp_pkg::CFG_WDOG, 9'h001, 1'b0, 1'b0), 16);
      exp_cfg[3] = 9'h001;
      chk(wdog_on_q, 1'b1);
      send(mk(scp_pkg::MODE_STOP, scp_pkg::CFG_WDOG, 9'h001, 1'b1, 1'b0), 16);
      chk(wdog_on_q, 1'b0);
      chk(meas_on_q, 1'b0);
      send(mk(scp_pkg::MODE_ACT_LIN_SLEEP, scp_pkg::CFG_WDOG, 9'h001, 1'b0, 1'b1), 16);
      send(mk(scp_pkg::MODE_STOP, scp_pkg::CFG_WDOG, 9'h001, 1'b0, 1'b1), 16);
      chk(wdog_on_q, 1'b1);
      send(mk(scp_pkg::MODE_ACT_LIN_ON, scp_pkg::CFG_WDOG, 9'h001, 1'b0, 1'b0), 16);
      chk(mode_q, scp_pkg::MODE_ACT_LIN_ON);
      low_load_current = 1'b0;
      chk_cfg();
   endtask

   // Wrong clock counts are discarded and flagged on the next frame.
   task automatic t_count();
      logic [15:0] badw;
      badw = mk(scp_pkg::MODE_STOP, scp_pkg::CFG_GENERAL, 9'h1FF, 1'b0, 1'b0);
      diag_word = 16'h8A52;
      send(badw, 15);
      chk(mode_q, scp_pkg::MODE_ACT_LIN_ON);
      send(mk(scp_pkg::MODE_ACT_LIN_SLEEP, scp_pkg::CFG_GENERAL, 9'h0F0, 1'b0, 1'b0), 16);
      exp_cfg[0] = 9'h0F0;
      send(badw, 17);
      send(badw, 0);
      chk(mode_q, scp_pkg::MODE_ACT_LIN_SLEEP);
      chk_cfg();
      send(mk(scp_pkg::MODE_ACT_LIN_ON, scp_pkg::CFG_SWITCH, 9'h05A, 1'b0, 1'b0), 32);
      exp_cfg[1] = 9'h05A;
      chk(mode_q, scp_pkg::MODE_ACT_LIN_ON);
      chk_cfg();
   endtask

   // ----------------------------------------
   // Main sequence and timeout
   // ----------------------------------------
   // Cuts a hang short after a fixed number of cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   // Reset, then every scenario in turn.
   initial
   begin
      repeat (4) @(posedge clk);
      #1;
      resetn = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      t_reset();
      t_fields();
      t_modes();
      t_wdog();
      t_count();
      close_out();
   end
endmodule
